// ### verification/testbench.sv
// self-checking bench for the temperature sensor readout core
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        i_mclk, i_srst, i_standby_pin_n, i_diode_fault;
  logic [7:0]  i_local_adc;
  logic [10:0] i_remote_adc;
  logic        scl, sda_h, sda_out, sda_oe_n, busy;
  logic [7:0]  cfg, d, le, re, lo;
  logic [2:0]  rf;
  logic [31:0] seed;
  wire logic   sda_w;
  int          n_mismatch, tests_run;
  assign sda_w = sda_h & (sda_oe_n | sda_out);
  tsr_core #(.P_CONV_CYC(20), .P_PERIOD_CYC(64), .P_TOUT_CYC(200)) dut (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_scl(scl), .i_sda(sda_w),
    .i_standby_pin_n(i_standby_pin_n), .i_local_adc(i_local_adc),
    .i_remote_adc(i_remote_adc), .i_diode_fault(i_diode_fault),
    .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .o_busy(busy), .o_config(cfg));
  tsr_host_model h (.i_sda(sda_w), .o_scl(scl), .o_sda_h(sda_h));
  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [7:0] emain(input logic [7:0] v, input logic xr);
    if (!v[7]) return v;
    if (!xr) return 8'h00;
    return ($signed(v) <= -64) ? 8'h80 : v;
  endfunction
  task automatic print_verdict();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wait_busy(input logic lvl, input int mx);
    int n;
    n = 0;
    while (busy !== lvl && n < mx) begin
      @(negedge i_mclk);
      n++;
    end
    chk8("busy", {7'h00, lvl}, {7'h00, busy});
    if (busy !== lvl) print_verdict();
  endtask
  task automatic no_conv(input int n);
    logic s;
    s = 1'b0;
    repeat (n) begin
      @(negedge i_mclk);
      s = s | busy;
    end
    chk8("idle_busy", 8'h00, {7'h00, s});
  endtask
  task automatic settle();
    repeat (2) begin
      wait_busy(1'b1, 400);
      wait_busy(1'b0, 100);
    end
  endtask
  task automatic new_adc(input logic neg);
    seed = xs(seed);
    le = {neg, seed[6:0]};
    re = {neg, seed[16:10]};
    rf = seed[20:18];
    @(posedge i_mclk);
    i_local_adc <= le;
    i_remote_adc <= {re, rf};
  endtask
  initial begin
    #8000000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    i_srst = 1'b1;
    i_standby_pin_n = 1'b1;
    i_diode_fault = 1'b0;
    i_local_adc = 8'h00;
    i_remote_adc = 11'h000;
    seed = 32'h55;
    n_mismatch = 0;
    tests_run = 0;
    repeat (16) @(posedge i_mclk);
    i_srst <= 1'b0;
    new_adc(1'b0);
    settle();
    h.recv_byte(d);
    chk8("rx_local", le, d);
    h.read_byte(8'h01, d);
    chk8("remote", re, d);
    h.read_byte(8'h10, d);
    chk8("frac_8hz", 8'h00, d);
    h.write_byte(8'h0a, 8'h04);
    new_adc(1'b0);
    settle();
    h.read_byte(8'h01, d);
    chk8("remote_4hz", re, d);
    h.read_byte(8'h10, d);
    chk8("frac_4hz", {rf, 5'h00}, d);
    h.recv_byte(d);
    chk8("rx_again", {rf, 5'h00}, d);
    h.write_byte(8'h09, 8'h08);
    new_adc(1'b1);
    settle();
    h.read_byte(8'h00, d);
    chk8("xr_local", emain(le, 1'b1), d);
    h.read_byte(8'h01, d);
    chk8("xr_remote", emain(re, 1'b1), d);
    h.write_byte(8'h09, 8'h00);
    @(posedge i_mclk);
    i_diode_fault <= 1'b1;
    settle();
    h.read_byte(8'h00, d);
    chk8("neg_local", emain(le, 1'b0), d);
    h.read_byte(8'h01, d);
    chk8("fault", 8'h80, d);
    h.write_byte(8'h09, 8'h40);
    chk8("config", 8'h40, cfg);
    @(posedge i_mclk);
    i_diode_fault <= 1'b0;
    new_adc(1'b0);
    no_conv(300);
    h.read_byte(8'h09, d);
    chk8("cfg_rd", 8'h40, d);
    h.read_byte(8'h00, d);
    chk8("hold_loc", 8'h00, d);
    h.t_lo = 12000;
    h.recv_byte(d);
    chk8("slow_rx", 8'h00, d);
    h.t_lo = 4400;
    fork
      h.send_byte(8'h0f);
      wait_busy(1'b1, 5000);
    join
    wait_busy(1'b0, 100);
    no_conv(300);
    h.read_byte(8'h00, d);
    chk8("os_local", le, d);
    h.read_byte(8'h01, d);
    chk8("os_remote", re, d);
    lo = le;
    @(posedge i_mclk);
    i_standby_pin_n <= 1'b0;
    new_adc(1'b0);
    fork
      h.send_byte(8'h0f);
      no_conv(3200);
    join
    h.write_byte(8'h09, 8'h00);
    no_conv(300);
    @(posedge i_mclk);
    i_standby_pin_n <= 1'b1;
    wait_busy(1'b1, 400);
    repeat (5) @(posedge i_mclk);
    i_standby_pin_n <= 1'b0;
    wait_busy(1'b0, 8);
    h.read_byte(8'h00, d);
    chk8("abort_loc", lo, d);
    @(posedge i_mclk);
    i_standby_pin_n <= 1'b1;
    settle();
    h.recv_byte(d);
    chk8("run_loc", le, d);
    chk8("acks", 8'h01, {7'h00, h.ok});
    print_verdict();
  end
endmodule
`default_nettype wire

// ### verification/tsr_host_model.sv
// smbus host model: single master using only the four byte protocols
`timescale 1ns/1ps
`default_nettype none
module tsr_host_model (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_h
);
  // only master on the bus, so the stored command byte is never changed behind its back
  localparam logic [6:0] ADR = 7'h4c;
  int unsigned t_lo;
  logic        ok;
  initial begin
    o_scl = 1'b1;
    o_sda_h = 1'b1;
    ok = 1'b1;
    t_lo = 4400;
  end
  // data moves well after the falling clock so no false start or stop is seen
  task automatic lo_phase(input logic b);
    #200 o_sda_h = b;
    #(t_lo - 200) o_scl = 1'b1;
  endtask
  task automatic wbit(input logic b);
    lo_phase(b);
    #1000 o_scl = 1'b0;
  endtask
  task automatic rbit(output logic b);
    lo_phase(1'b1);
    #500 b = i_sda;
    #500 o_scl = 1'b0;
  endtask
  task automatic start();
    lo_phase(1'b1);
    #1000 o_sda_h = 1'b0;
    #1000 o_scl = 1'b0;
  endtask
  task automatic stop();
    lo_phase(1'b0);
    #1000 o_sda_h = 1'b1;
    #1000;
  endtask
  task automatic wbyte(input logic [7:0] d);
    logic a;
    for (int i = 7; i >= 0; i--) wbit(d[i]);
    rbit(a);
    if (a !== 1'b0) ok = 1'b0;
  endtask
  task automatic rbyte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    wbit(1'b1);
  endtask
  task automatic send_byte(input logic [7:0] c);
    start();
    wbyte({ADR, 1'b0});
    wbyte(c);
    stop();
  endtask
  task automatic write_byte(input logic [7:0] c, input logic [7:0] v);
    start();
    wbyte({ADR, 1'b0});
    wbyte(c);
    wbyte(v);
    stop();
  endtask
  // command first selects the register, then repeated start for the data
  task automatic read_byte(input logic [7:0] c, output logic [7:0] d);
    start();
    wbyte({ADR, 1'b0});
    wbyte(c);
    start();
    wbyte({ADR, 1'b1});
    rbyte(d);
    stop();
  endtask
  task automatic recv_byte(output logic [7:0] d);
    start();
    wbyte({ADR, 1'b1});
    rbyte(d);
    stop();
  endtask
endmodule
`default_nettype wire

// ### verilog/tsr_core.sv
// temperature sensor readout: standby, conversion sequencing, registers, bus framing
`timescale 1ns/1ps
`default_nettype none
`include "tsr_params.svh"
module tsr_core #(
  parameter int unsigned P_CONV_CYC   = `TSR_CONV_MS * (`TSR_CLK_HZ / 1000),
  parameter int unsigned P_PERIOD_CYC = `TSR_PERIOD_MS * (`TSR_CLK_HZ / 1000),
  parameter int unsigned P_TOUT_CYC   = `TSR_TOUT_MS * (`TSR_CLK_HZ / 1000)
) (
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  input  wire logic        i_standby_pin_n,
  input  wire logic [7:0]  i_local_adc,
  input  wire logic [10:0] i_remote_adc,
  input  wire logic        i_diode_fault,
  output logic             o_sda_out,
  output logic             o_sda_oe_n,
  output logic             o_busy,
  output logic [7:0]       o_config
);
  tsr_pkg::tsr_core_st_t s;
  tsr_pkg::tsr_core_st_t n;

  logic [4:0] sy;
  logic       sy_scl;
  logic       sy_sda;
  logic       sy_standby_pin_n_n;
  logic       sy_cmd;
  logic       sy_dat;
  logic       cmd_tgl;
  logic       dat_tgl;
  logic [7:0] link_cmd;
  logic [7:0] link_dat;
  logic       start;
  logic       stop;
  logic       hw_standby_pin_n;
  logic       standby_pin_n;
  logic       cmd_ev;
  logic       dat_ev;
  logic       oneshot;
  logic       halt_req;
  logic       abort;
  logic       conv_done;
  logic       xr;
  logic [7:0] rem_int;
  logic [7:0] rem_c;

  // read view of the register set
  function automatic logic [7:0] f_rd(input tsr_pkg::tsr_core_st_t c, input logic [7:0] ptr);
    logic [7:0] v;
    v = 8'h00;
    case (ptr)
      `TSR_OFS_LOCAL:  v = c.loc;
      `TSR_OFS_REMOTE: v = c.rem;
      `TSR_OFS_FRAC:   v = c.frac;
      `TSR_OFS_CONFIG: v = c.cfg;
      `TSR_OFS_RATE:   v = c.rate;
      `TSR_OFS_STATUS: v[`TSR_STAT_BUSY] = c.busy;
      default:         v = 8'h00;
    endcase
    return v;
  endfunction

  // legacy clamps negatives to zero, extended range maps -64 and below to 80h
  function automatic logic [7:0] f_clamp(input logic [7:0] t, input logic ext);
    logic [7:0] v;
    v = t;
    if (t[7] && !ext) begin
      v = 8'h00;
    end else if (t[7] && ext && $signed(t) <= $signed(`TSR_XR_FLOOR)) begin
      v = `TSR_FAULT_CODE;
    end
    return v;
  endfunction

  tsr_sync #(
    .W (5)
  ) u_sync (
    .i_clk  (i_mclk),
    .i_srst (i_srst),
    .i_d    ({i_scl, i_sda, i_standby_pin_n, cmd_tgl, dat_tgl}),
    .o_q    (sy)
  );

  tsr_link u_link (
    .i_scl      (i_scl),
    .i_link_rst (s.link_rst),
    .i_sda      (i_sda),
    .i_rd_data  (s.snap),
    .o_sda_out  (o_sda_out),
    .o_sda_oe_n (o_sda_oe_n),
    .o_cmd_tgl  (cmd_tgl),
    .o_cmd      (link_cmd),
    .o_dat_tgl  (dat_tgl),
    .o_dat      (link_dat)
  );

  assign {sy_scl, sy_sda, sy_standby_pin_n_n, sy_cmd, sy_dat} = sy;

  always_comb begin
    n         = s;
    start     = sy_scl & s.sda_q & ~sy_sda;
    stop      = sy_scl & ~s.sda_q & sy_sda;
    hw_standby_pin_n   = ~sy_standby_pin_n_n;
    standby_pin_n      = hw_standby_pin_n | s.cfg[`TSR_CFG_HALT];
    cmd_ev    = (sy_cmd ^ s.cmd_q) & ~s.link_rst;
    dat_ev    = (sy_dat ^ s.dat_q) & ~s.link_rst;
    n.sda_q   = sy_sda;
    n.cmd_q   = sy_cmd;
    n.dat_q   = sy_dat;
    xr        = s.cfg[`TSR_CFG_XRANGE];
    rem_int   = i_remote_adc[10:3];
    rem_c     = f_clamp(rem_int, xr);
    conv_done = (s.ccnt == P_CONV_CYC - 1);

    // framing: hold the link engine in reset between frames
    if (start) begin
      n.link_rst = 1'b1;
      n.arm      = 1'b1;
      n.in_frame = 1'b0;
    end else if (stop) begin
      n.link_rst = 1'b1;
      n.arm      = 1'b0;
      n.in_frame = 1'b0;
    end else if (s.in_frame && !standby_pin_n && s.to_cnt >= P_TOUT_CYC - 1) begin
      n.link_rst = 1'b1;
      n.in_frame = 1'b0;
    end else if (s.arm && !sy_scl) begin
      n.link_rst = 1'b0;
      n.arm      = 1'b0;
      n.in_frame = 1'b1;
    end
    if (s.in_frame && !sy_scl && !standby_pin_n) begin
      n.to_cnt = s.to_cnt + 32'h1;
    end else begin
      n.to_cnt = 32'h0;
    end
    if (s.link_rst) begin
      n.snap = f_rd(s, s.ptr);
    end

    // command and data bytes from the link
    oneshot = 1'b0;
    if (cmd_ev) begin
      n.ptr   = link_cmd;
      oneshot = (link_cmd == `TSR_OFS_ONESHOT);
    end
    halt_req = 1'b0;
    if (dat_ev) begin
      case (s.ptr)
        `TSR_OFS_CONFIG: begin
          n.cfg    = link_dat;
          halt_req = link_dat[`TSR_CFG_HALT];
        end
        `TSR_OFS_RATE: n.rate = (link_dat > `TSR_RATE_MAX) ? `TSR_RATE_MAX : link_dat;
        default: begin
        end
      endcase
    end
    abort = hw_standby_pin_n | halt_req;

    // conversion sequencer
    n.tmr = (s.tmr == 32'h0) ? 32'h0 : s.tmr - 32'h1;
    case (s.st)
      tsr_pkg::CV_IDLE: begin
        if (!hw_standby_pin_n && (oneshot || (!s.cfg[`TSR_CFG_HALT] && s.tmr == 32'h0))) begin
          n.st   = tsr_pkg::CV_LOC;
          n.busy = 1'b1;
          n.ccnt = 32'h0;
          n.tmr  = P_PERIOD_CYC << (3'd5 - s.rate[2:0]);
        end
      end
      tsr_pkg::CV_LOC: begin
        if (abort) begin
          n.st   = tsr_pkg::CV_IDLE;
          n.busy = 1'b0;
        end else if (conv_done) begin
          n.l_meas = i_local_adc;
          n.st     = tsr_pkg::CV_REM;
          n.ccnt   = 32'h0;
        end else begin
          n.ccnt = s.ccnt + 32'h1;
        end
      end
      tsr_pkg::CV_REM: begin
        if (abort) begin
          n.st   = tsr_pkg::CV_IDLE;
          n.busy = 1'b0;
        end else if (conv_done) begin
          n.st   = tsr_pkg::CV_IDLE;
          n.busy = 1'b0;
          n.loc  = f_clamp(s.l_meas, xr);
          n.rem  = i_diode_fault ? `TSR_FAULT_CODE : rem_c;
          n.frac = 8'h00;
          if (!i_diode_fault && rem_c == rem_int && s.rate <= `TSR_RATE_XRES_MAX) begin
            n.frac = {i_remote_adc[2:0], 5'h00};
          end
        end else begin
          n.ccnt = s.ccnt + 32'h1;
        end
      end
      default: n.st = tsr_pkg::CV_IDLE;
    endcase

    if (i_srst) begin
      n          = '0;
      n.link_rst = 1'b1;
      n.ptr      = `TSR_PTR_RST;
      n.cfg      = `TSR_CFG_RST;
      n.rate     = `TSR_RATE_RST;
      n.st       = tsr_pkg::CV_IDLE;
    end
  end

  always_ff @(posedge i_mclk) begin
    s <= n;
  end

  assign o_busy   = s.busy;
  assign o_config = s.cfg;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);

  pin_standby_halts_a: assert property (hw_standby_pin_n && s.st == tsr_pkg::CV_IDLE |=> s.st == tsr_pkg::CV_IDLE)
    else $error("conversion started in pin standby");
  standby_aborts_a: assert property (s.st != tsr_pkg::CV_IDLE && hw_standby_pin_n |=> s.st == tsr_pkg::CV_IDLE && !s.busy)
    else $error("pin standby did not abort conversion");
  abort_keeps_results_a: assert property (s.st != tsr_pkg::CV_IDLE && abort |=> $stable(s.loc) && $stable(s.rem)
                                          && $stable(s.frac))
    else $error("aborted conversion changed results");
  busy_tracks_a: assert property (s.busy == (s.st != tsr_pkg::CV_IDLE))
    else $error("busy flag disagrees with converter state");
  fault_code_a: assert property (s.st == tsr_pkg::CV_REM && conv_done && !abort && i_diode_fault
                                 |=> s.rem == `TSR_FAULT_CODE)
    else $error("fault code not loaded");
  soft_oneshot_a: assert property (s.st == tsr_pkg::CV_IDLE && oneshot && !hw_standby_pin_n
                                   |=> s.st == tsr_pkg::CV_LOC ##1 s.busy)
    else $error("one-shot did not start conversion");
  timeout_off_a: assert property (s.in_frame && standby_pin_n && !start && !stop |=> s.in_frame)
    else $error("bus timeout fired in standby");
  ptr_reset_a: assert property ($past(i_srst) |-> s.ptr == `TSR_PTR_RST || cmd_ev)
    else $error("command byte not cleared by reset");
  local_first_a: assert property (s.st == tsr_pkg::CV_REM |-> $past(s.st) != tsr_pkg::CV_IDLE)
    else $error("remote measured without local");
  fast_no_frac_a: assert property (s.st == tsr_pkg::CV_REM && conv_done && !abort && s.rate > `TSR_RATE_XRES_MAX
                                   |=> s.frac == 8'h00)
    else $error("fraction supplied at fast rate");

  conv_complete_c: cover property (s.st == tsr_pkg::CV_REM ##1 s.st == tsr_pkg::CV_IDLE);
  oneshot_c: cover property (oneshot && s.cfg[`TSR_CFG_HALT] ##1 s.st == tsr_pkg::CV_LOC);
  abort_c: cover property (s.st == tsr_pkg::CV_REM && abort);
  timeout_c: cover property (s.in_frame ##1 !s.in_frame && !start && !stop);
endmodule
`default_nettype wire

// ### verilog/tsr_link.sv
// serial bus slave engine clocked by the bus clock
`timescale 1ns/1ps
`default_nettype none
`include "tsr_params.svh"
module tsr_link (
  input  wire logic       i_scl,
  input  wire logic       i_link_rst,
  input  wire logic       i_sda,
  input  wire logic [7:0] i_rd_data,
  output logic            o_sda_out,
  output logic            o_sda_oe_n,
  output logic            o_cmd_tgl,
  output logic [7:0]      o_cmd,
  output logic            o_dat_tgl,
  output logic [7:0]      o_dat
);
  tsr_pkg::tsr_link_st_t s_r;
  tsr_pkg::tsr_link_st_t s_nxt;
  logic                  oe_n_r;
  logic                  drive_low;
  logic [7:0]            byte_in;

  always_comb begin
    s_nxt   = s_r;
    byte_in = {s_r.sh[6:0], i_sda};
    if (s_r.cnt != 4'h8) begin
      s_nxt.sh  = byte_in;
      s_nxt.cnt = s_r.cnt + 4'h1;
      s_nxt.ack = 1'b0;
      if (s_r.cnt == 4'h7) begin
        case (s_r.ph)
          tsr_pkg::LK_ADDR: begin
            if (byte_in[7:1] == `TSR_SLAVE_ADDR) begin
              s_nxt.ack = 1'b1;
              if (byte_in[0]) begin
                s_nxt.ph = tsr_pkg::LK_READ;
                s_nxt.tx = i_rd_data;
              end else begin
                s_nxt.ph = tsr_pkg::LK_CMD;
              end
            end else begin
              s_nxt.ph = tsr_pkg::LK_IDLE;
            end
          end
          tsr_pkg::LK_CMD: begin
            s_nxt.ack     = 1'b1;
            s_nxt.cmd     = byte_in;
            s_nxt.cmd_tgl = ~s_r.cmd_tgl;
            s_nxt.ph      = tsr_pkg::LK_DATA;
          end
          tsr_pkg::LK_DATA: begin
            s_nxt.ack     = 1'b1;
            s_nxt.dat     = byte_in;
            s_nxt.dat_tgl = ~s_r.dat_tgl;
            s_nxt.ph      = tsr_pkg::LK_IDLE;
          end
          default: begin
          end
        endcase
      end
    end else begin
      s_nxt.cnt = 4'h0;
      s_nxt.ack = 1'b0;
      if (s_r.ph == tsr_pkg::LK_READ) begin
        if (i_sda) begin
          s_nxt.ph = tsr_pkg::LK_IDLE;
        end else begin
          s_nxt.tx = i_rd_data;
        end
      end
    end
  end

  always_comb begin
    drive_low = s_r.ack;
    if (s_r.ph == tsr_pkg::LK_READ && s_r.cnt != 4'h8) begin
      drive_low = ~s_r.tx[3'(4'h7 - s_r.cnt)];
    end
  end

  always_ff @(posedge i_scl or posedge i_link_rst) begin
    if (i_link_rst) begin
      s_r <= '{ph: tsr_pkg::LK_ADDR, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  always_ff @(negedge i_scl or posedge i_link_rst) begin
    if (i_link_rst) begin
      oe_n_r    <= 1'b1;
      o_sda_out <= 1'b0;
    end else begin
      oe_n_r    <= ~drive_low;
      o_sda_out <= 1'b0;
    end
  end

  assign o_sda_oe_n = oe_n_r;
  assign o_cmd_tgl  = s_r.cmd_tgl;
  assign o_cmd      = s_r.cmd;
  assign o_dat_tgl  = s_r.dat_tgl;
  assign o_dat      = s_r.dat;
endmodule
`default_nettype wire

// ### verilog/tsr_params.svh
// constants for the temperature sensor readout block
// Overview of operation
// - converter stops in pin or software standby
// - standby keeps registers, bus; timeout suspended
// - one-shot converts in software standby or while running, not in pin standby
// - standby pin overrides all software conversion requests
// - standby aborts conversion, results keep old values
// - byte registers behind one slave address
// - only write, read, send, receive byte
// - receive byte returns last stored command register
// - results are signed degrees, one per lsb
// - read bytes leave msb first
// - config bit 3 enables range to -63, -64 and below read 80h
// - fraction bits only at 4hz or slower
// - main and fraction update from same measurement
// - halt bit plus command 0fh converts once
// - busy flag high exactly while converting
// - junction fault loads remote with 1000 0000
// - fraction in upper three bits, eighths
// - command byte resets to zero
// - every cycle measures local then remote
`ifndef TSR_PARAMS_SVH
`define TSR_PARAMS_SVH

`define TSR_SLAVE_ADDR    7'h4c
`define TSR_OFS_LOCAL     8'h00
`define TSR_OFS_REMOTE    8'h01
`define TSR_OFS_STATUS    8'h02
`define TSR_OFS_CONFIG    8'h09
`define TSR_OFS_RATE      8'h0a
`define TSR_OFS_ONESHOT   8'h0f
`define TSR_OFS_FRAC      8'h10

`define TSR_CFG_XRANGE    3
`define TSR_CFG_HALT      6
`define TSR_STAT_BUSY     7

`define TSR_PTR_RST       8'h00
`define TSR_CFG_RST       8'h00
`define TSR_RATE_RST      8'h05
`define TSR_RATE_MAX      8'h05
`define TSR_RATE_XRES_MAX 8'h04
`define TSR_FAULT_CODE    8'h80
`define TSR_XR_FLOOR      8'hc0

`define TSR_CLK_HZ        25000000
`define TSR_CONV_MS       60
`define TSR_PERIOD_MS     125
`define TSR_TOUT_MS       25

`endif

// ### verilog/tsr_pkg.sv
// types shared by the temperature sensor readout block
package tsr_pkg;

  typedef enum logic [1:0] {CV_IDLE, CV_LOC, CV_REM} tsr_conv_t;

  typedef enum logic [2:0] {LK_ADDR, LK_CMD, LK_DATA, LK_READ, LK_IDLE} tsr_phase_t;

  typedef struct packed {
    logic        sda_q;
    logic        cmd_q;
    logic        dat_q;
    logic        link_rst;
    logic        arm;
    logic        in_frame;
    logic [31:0] to_cnt;
    logic [7:0]  ptr;
    logic [7:0]  cfg;
    logic [7:0]  rate;
    logic [7:0]  snap;
    tsr_conv_t   st;
    logic        busy;
    logic [31:0] tmr;
    logic [31:0] ccnt;
    logic [7:0]  l_meas;
    logic [7:0]  loc;
    logic [7:0]  rem;
    logic [7:0]  frac;
  } tsr_core_st_t;

  typedef struct packed {
    tsr_phase_t ph;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic       ack;
    logic       cmd_tgl;
    logic [7:0] cmd;
    logic       dat_tgl;
    logic [7:0] dat;
  } tsr_link_st_t;

endpackage

// ### verilog/tsr_sync.sv
// two-flop level synchroniser into the system clock
`timescale 1ns/1ps
`default_nettype none
module tsr_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [1:0][W-1:0] q_r;
  logic [1:0][W-1:0] q_nxt;

  always_comb begin
    q_nxt = q_r;
    if (i_srst) begin
      q_nxt = '0;
    end else begin
      q_nxt[0] = i_d;
      q_nxt[1] = q_r[0];
    end
  end

  always_ff @(posedge i_clk) begin
    q_r <= q_nxt;
  end

  assign o_q = q_r[1];
endmodule
`default_nettype wire
